// File: rtl/dcmc_core_ctrl.sv
// Converter core feeding mode, clock trim and serial register port
// clk is the half-cycle rate of the converter clock: each rising clk edge starts one
// half-cycle, alternating rising-half and falling-half phases.
`timescale 1ns/100ps
module dcmc_core_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [dcmc_pkg::SAMPLE_W-1:0] smp_data,
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic half_band_doubling_filter_en,
  input wire logic spi_sclk,
  input wire logic spi_csb_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe_n,
  output dcmc_pkg::dcmc_core_s core_out,
  output logic [2:0] shuffle_sel,
  output logic shuffle_en,
  output dcmc_pkg::dcmc_trim_s trim_out,
  output logic [8*dcmc_pkg::DLL_NREG-1:0] dll_cfg,
  output logic underrun
);
  import dcmc_pkg::*;

  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_INSTR = 2'b01,
    SP_DATA = 2'b10
  } dcmc_spi_e;

  // Register storage
  logic [7:0] skew_trim_r;
  logic [7:0] duty_adj_r;
  logic [7:0] shuffle_ctl_r;
  logic [7:0] mode_sel_r;
  logic [7:0] dll_r [DLL_NREG];

  // Serial pin synchronisers and filtered levels
  logic [2:0] sclk_s;
  logic [2:0] csb_s;
  logic [2:0] sdi_s;
  logic sclk_f_r;
  logic csb_f_r;
  logic sdi_f_r;
  logic sclk_rise;
  logic sclk_fall;

  // Serial engine
  dcmc_spi_e spi_st_r;
  dcmc_spi_e spi_st_nxt;
  logic [4:0] bit_cnt_r;
  logic [23:0] shift_r;
  logic [7:0] rd_shift_r;
  logic rd_flag_r;
  logic wr_strobe;
  logic [14:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  // Datapath
  logic phase_r;
  dcmc_mode_e act_mode_r;
  logic [15:0] held_r;
  logic [15:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic dbl_active;
  logic [15:0] lfsr_state;

  // Address to read value, unused bits masked
  function automatic logic [7:0] reg_read(input logic [14:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_SKEW_TRIM: v = skew_trim_r & MASK_SKEW_TRIM;
      ADDR_DUTY_ADJ: v = duty_adj_r & MASK_DUTY_ADJ;
      ADDR_SHUFFLE: v = shuffle_ctl_r & MASK_SHUFFLE;
      ADDR_MODE_SEL: v = mode_sel_r & MASK_MODE_SEL;
      default: begin
        if (a >= ADDR_DLL_FIRST && a <= ADDR_DLL_LAST) begin
          v = dll_r[4'(a - ADDR_DLL_FIRST)];
        end else begin
          v = 8'h00;
        end
      end
    endcase
    return v;
  endfunction

  // Sign-magnitude trim to per-side step counts
  function automatic logic [9:0] split_sm(input logic neg,
                                          input logic [4:0] mag);
    return neg ? {5'h00, mag} : {mag, 5'h00};
  endfunction

  // Three-stage synchronisers on the serial pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s <= 3'h0;
      csb_s <= 3'h7;
      sdi_s <= 3'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], spi_sclk};
      csb_s <= {csb_s[1:0], spi_csb_n};
      sdi_s <= {sdi_s[1:0], spi_sdi};
    end
  end

  // Filtered levels change once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_f_r <= 1'b0;
      csb_f_r <= 1'b1;
      sdi_f_r <= 1'b0;
    end else begin
      if (sclk_s[1] == sclk_s[2]) begin
        sclk_f_r <= sclk_s[2];
      end
      if (csb_s[1] == csb_s[2]) begin
        csb_f_r <= csb_s[2];
      end
      if (sdi_s[1] == sdi_s[2]) begin
        sdi_f_r <= sdi_s[2];
      end
    end
  end

  // Serial clock edges, valid only inside a frame
  assign sclk_rise = !csb_f_r && (sclk_s[1] == sclk_s[2]) &&
                     sclk_s[2] && !sclk_f_r;
  assign sclk_fall = !csb_f_r && (sclk_s[1] == sclk_s[2]) &&
                     !sclk_s[2] && sclk_f_r;

  // Frame state, next value
  always_comb begin
    spi_st_nxt = spi_st_r;
    case (spi_st_r)
      SP_IDLE: begin
        if (!csb_f_r) begin
          spi_st_nxt = SP_INSTR;
        end
      end
      SP_INSTR: begin
        if (csb_f_r) begin
          spi_st_nxt = SP_IDLE;
        end else if (sclk_rise &&
                     bit_cnt_r == 5'(SPI_INSTR_BITS - 1)) begin
          spi_st_nxt = SP_DATA;
        end
      end
      SP_DATA: begin
        if (csb_f_r) begin
          spi_st_nxt = SP_IDLE;
        end else if (sclk_rise &&
                     bit_cnt_r == 5'(SPI_FRAME_BITS - 1)) begin
          spi_st_nxt = SP_IDLE;
        end
      end
      default: spi_st_nxt = SP_IDLE;
    endcase
  end

  // Frame state register; a finished frame waits for chip select high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_st_r <= SP_IDLE;
    end else if (spi_st_r == SP_IDLE && bit_cnt_r != 5'h00 && !csb_f_r) begin
      spi_st_r <= SP_IDLE;
    end else begin
      spi_st_r <= spi_st_nxt;
    end
  end

  // Bit counter and input shift register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= 5'h00;
      shift_r <= 24'h000000;
    end else if (csb_f_r) begin
      bit_cnt_r <= 5'h00;
    end else if (sclk_rise && spi_st_r != SP_IDLE) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
      shift_r <= {shift_r[22:0], sdi_f_r};
    end
  end

  // Read flag latched with the first instruction bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_flag_r <= 1'b0;
    end else if (csb_f_r) begin
      rd_flag_r <= 1'b0;
    end else if (sclk_rise && spi_st_r == SP_INSTR &&
                 bit_cnt_r == 5'h00) begin
      rd_flag_r <= sdi_f_r;
    end
  end

  // Write commits on the last data bit
  assign wr_strobe = sclk_rise && spi_st_r == SP_DATA && !rd_flag_r &&
                     bit_cnt_r == 5'(SPI_FRAME_BITS - 1);
  assign wr_addr = shift_r[21:7];
  assign wr_data = {shift_r[6:0], sdi_f_r};
  always_comb rd_data = reg_read({shift_r[13:0], sdi_f_r});

  // Read data: loaded after the address, shifted out on falling edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_shift_r <= 8'h00;
      spi_sdo <= 1'b0;
      spi_sdo_oe_n <= 1'b1;
    end else if (csb_f_r) begin
      spi_sdo <= 1'b0;
      spi_sdo_oe_n <= 1'b1;
    end else if (sclk_rise && spi_st_r == SP_INSTR &&
                 bit_cnt_r == 5'(SPI_INSTR_BITS - 1)) begin
      rd_shift_r <= rd_data;
    end else if (sclk_fall && spi_st_r == SP_DATA && rd_flag_r) begin
      spi_sdo <= rd_shift_r[7];
      spi_sdo_oe_n <= 1'b0;
      rd_shift_r <= {rd_shift_r[6:0], 1'b0};
    end else if (spi_st_r != SP_DATA) begin
      spi_sdo_oe_n <= 1'b1;
    end
  end

  // Control registers written from the serial port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      skew_trim_r <= RST_SKEW_TRIM;
      duty_adj_r <= RST_DUTY_ADJ;
      shuffle_ctl_r <= RST_SHUFFLE;
      mode_sel_r <= RST_MODE_SEL;
    end else if (wr_strobe) begin
      case (wr_addr)
        ADDR_SKEW_TRIM: skew_trim_r <= wr_data & MASK_SKEW_TRIM;
        ADDR_DUTY_ADJ: duty_adj_r <= wr_data & MASK_DUTY_ADJ;
        ADDR_SHUFFLE: shuffle_ctl_r <= wr_data & MASK_SHUFFLE;
        ADDR_MODE_SEL: mode_sel_r <= wr_data & MASK_MODE_SEL;
        default: ;
      endcase
    end
  end

  // Locking-loop settings, stored as loaded by the host
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DLL_NREG; i++) begin
        dll_r[i] <= RST_DLL;
      end
    end else if (wr_strobe && wr_addr >= ADDR_DLL_FIRST &&
                 wr_addr <= ADDR_DLL_LAST) begin
      dll_r[4'(wr_addr - ADDR_DLL_FIRST)] <= wr_data;
    end
  end

  // Locking-loop settings out to the analog loop
  always_comb begin
    for (int i = 0; i < DLL_NREG; i++) begin
      dll_cfg[8*i +: 8] = dll_r[i];
    end
  end

  // Clock input trim decode
  always_comb begin
    trim_out.duty_corr_en = duty_adj_r[DUTY_CORR_BIT];
    // Offset applies only when offset use is enabled
    if (duty_adj_r[DUTY_OFFS_EN_BIT]) begin
      trim_out.duty_offs_neg = duty_adj_r[DUTY_SIGN_BIT];
      trim_out.duty_offs_mag = duty_adj_r[3:0];
    end else begin
      trim_out.duty_offs_neg = 1'b0;
      trim_out.duty_offs_mag = 4'h0;
    end
    {trim_out.cap_pos_steps, trim_out.cap_neg_steps} =
      split_sm(skew_trim_r[SKEW_SIGN_BIT], skew_trim_r[4:0]);
  end

  // Sample FIFO between upstream datapath and core feed
  dcmc_fifo #(
    .W(SAMPLE_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(smp_data),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // Half-cycle phase: 0 rising half, 1 falling half
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end

  // Mode adopted only as a new period starts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_mode_r <= DCMC_NRZ;
    end else if (phase_r) begin
      act_mode_r <= dcmc_mode_e'(mode_sel_r[1:0]);
    end
  end

  // Doubling filter feeds a fresh sample every half-cycle in NRZ
  assign dbl_active = half_band_doubling_filter_en &&
                      (act_mode_r == DCMC_NRZ ||
                       act_mode_r == DCMC_RSVD);
  assign fifo_pop = !phase_r || dbl_active;

  // Sample held from the rising half for the falling half
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_r <= ZERO_WORD;
    end else if (!phase_r) begin
      held_r <= fifo_valid ? fifo_data : ZERO_WORD;
    end
  end

  // Underrun flag for the half-cycle that found no sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      underrun <= 1'b0;
    end else begin
      underrun <= fifo_pop && !fifo_valid;
    end
  end

  // Core word and switch pair for each half-cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_out.word <= ZERO_WORD;
      core_out.pair_en <= PAIR_RISE;
      core_out.rise_half <= 1'b0;
    end else begin
      core_out.rise_half <= !phase_r;
      core_out.pair_en <= phase_r ? PAIR_FALL : PAIR_RISE;
      if (!phase_r) begin
        core_out.word <= fifo_valid ? fifo_data : ZERO_WORD;
      end else begin
        case (act_mode_r)
          DCMC_RZ: core_out.word <= ZERO_WORD;
          DCMC_CHOP: core_out.word <= ~held_r;
          default: begin
            if (dbl_active) begin
              core_out.word <= fifo_valid ? fifo_data : ZERO_WORD;
            end else begin
              core_out.word <= held_r;
            end
          end
        endcase
      end
    end
  end

  // Random source advanced once per sample
  dcmc_lfsr u_lfsr (
    .clk(clk),
    .rst_n(rst_n),
    .advance(fifo_pop),
    .state(lfsr_state)
  );

  // Shuffle selection for the most significant current cells
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shuffle_sel <= 3'h0;
      shuffle_en <= 1'b0;
    end else begin
      shuffle_en <= shuffle_ctl_r[SHUFFLE_EN_BIT];
      shuffle_sel <= shuffle_ctl_r[SHUFFLE_EN_BIT] ?
                     lfsr_state[2:0] : 3'h0;
    end
  end
endmodule

// File: rtl/dcmc_pkg.sv
// Shared constants and types for the converter core mode and clock control
package dcmc_pkg;
  // Register map, byte addresses on the serial port
  localparam logic [14:0] ADDR_SKEW_TRIM = 15'h007f;
  localparam logic [14:0] ADDR_DUTY_ADJ = 15'h0082;
  localparam logic [14:0] ADDR_DLL_FIRST = 15'h0090;
  localparam logic [14:0] ADDR_DLL_LAST = 15'h009b;
  localparam logic [14:0] ADDR_SHUFFLE = 15'h0151;
  localparam logic [14:0] ADDR_MODE_SEL = 15'h0152;
  localparam int DLL_NREG = 12;

  // Values after reset
  localparam logic [7:0] RST_SKEW_TRIM = 8'h00;
  localparam logic [7:0] RST_DUTY_ADJ = 8'h00;
  localparam logic [7:0] RST_DLL = 8'h00;
  localparam logic [7:0] RST_SHUFFLE = 8'h00;
  localparam logic [7:0] RST_MODE_SEL = 8'h00;

  // Field positions
  localparam int DUTY_CORR_BIT = 7;
  localparam int DUTY_OFFS_EN_BIT = 6;
  localparam int DUTY_SIGN_BIT = 4;
  localparam int SKEW_SIGN_BIT = 5;
  localparam int SHUFFLE_EN_BIT = 2;

  // Read masks: unused bits read as zero
  localparam logic [7:0] MASK_SKEW_TRIM = 8'h3f;
  localparam logic [7:0] MASK_DUTY_ADJ = 8'hdf;
  localparam logic [7:0] MASK_SHUFFLE = 8'h04;
  localparam logic [7:0] MASK_MODE_SEL = 8'h03;

  // Serial frame: read flag, 15-bit address, 8-bit data
  localparam int SPI_INSTR_BITS = 16;
  localparam int SPI_FRAME_BITS = 24;

  // Datapath
  localparam int SAMPLE_W = 16;
  localparam int FIFO_DEPTH = 4;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [1:0] PAIR_RISE = 2'b01;
  localparam logic [1:0] PAIR_FALL = 2'b10;

  // Core feeding modes
  typedef enum logic [1:0] {
    DCMC_NRZ = 2'b00,
    DCMC_CHOP = 2'b01,
    DCMC_RZ = 2'b10,
    DCMC_RSVD = 2'b11
  } dcmc_mode_e;

  // One half-cycle word to the switch core
  typedef struct packed {
    logic [15:0] word;
    logic [1:0] pair_en;
    logic rise_half;
  } dcmc_core_s;

  // Clock input trim settings
  typedef struct packed {
    logic duty_corr_en;
    logic duty_offs_neg;
    logic [3:0] duty_offs_mag;
    logic [4:0] cap_pos_steps;
    logic [4:0] cap_neg_steps;
  } dcmc_trim_s;
endpackage

// File: rtl/dcmc_fifo.sv
// Sample FIFO with valid/ready on both sides
`timescale 1ns/100ps
module dcmc_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Honest full and empty from the fill count
  assign in_ready = (count_r != D[AW:0]);
  assign out_valid = (count_r != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_r];

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(D - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(D - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// File: rtl/dcmc_lfsr.sv
// Pseudo-random source for current-cell shuffling
`timescale 1ns/100ps
module dcmc_lfsr (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic advance,
  output logic [15:0] state
);
  import dcmc_pkg::*;
  logic [15:0] state_r;

  // Galois LFSR, taps 16,14,13,11
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= LFSR_SEED;
    end else if (advance) begin
      state_r <= {1'b0, state_r[15:1]} ^ (state_r[0] ? 16'hb400 : 16'h0000);
    end
  end

  assign state = state_r;
endmodule

// File: verif/dcmc_core_ctrl_asserts.sv
// Port-level temporal checks for the core control block
`timescale 1ns/100ps
module dcmc_core_ctrl_asserts
  import dcmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic half_band_doubling_filter_en,
  input wire logic spi_csb_n,
  input wire logic spi_sdo_oe_n,
  input wire dcmc_pkg::dcmc_core_s core_out,
  input wire logic [2:0] shuffle_sel,
  input wire logic shuffle_en,
  input wire dcmc_pkg::dcmc_trim_s trim_out,
  input wire logic [8*dcmc_pkg::DLL_NREG-1:0] dll_cfg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Two clean edges since reset release
  sequence s_live;
    rst_n && $past(rst_n) && $past(rst_n, 2);
  endsequence
  // Rising half with the doubling filter held off
  sequence s_rise_plain;
    s_live ##0 (!half_band_doubling_filter_en)[*4] ##0 core_out.rise_half;
  endsequence
  property p_pair_match;
    s_live |-> core_out.pair_en == (core_out.rise_half ? PAIR_RISE : PAIR_FALL);
  endproperty
  a_pair_match: assert property (p_pair_match)
    else $error("switch pair does not match half-cycle");
  property p_alternate;
    s_live |-> core_out.rise_half != $past(core_out.rise_half);
  endproperty
  a_alternate: assert property (p_alternate)
    else $error("half-cycle phase did not alternate");
  property p_fall_word;
    s_rise_plain ##1 (!core_out.rise_half && !half_band_doubling_filter_en)
      |-> core_out.word == $past(core_out.word) || core_out.word == ZERO_WORD
      || core_out.word == ~$past(core_out.word);
  endproperty
  a_fall_word: assert property (p_fall_word)
    else $error("falling half word not held, zero or complement");
  property p_shuffle_off;
    !shuffle_en && $past(!shuffle_en) |-> shuffle_sel == 3'h0;
  endproperty
  a_shuffle_off: assert property (p_shuffle_off)
    else $error("cell selection moves with shuffle off");
  property p_skew_side;
    trim_out.cap_pos_steps == 5'h00 || trim_out.cap_neg_steps == 5'h00;
  endproperty
  a_skew_side: assert property (p_skew_side)
    else $error("skew trim loads both clock inputs");
  property p_cfg_stable;
    spi_csb_n[*8] |-> $stable({trim_out, shuffle_en, dll_cfg});
  endproperty
  a_cfg_stable: assert property (p_cfg_stable)
    else $error("settings changed with no frame");
  property p_oe_idle;
    spi_csb_n[*6] |-> spi_sdo_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("read line driven while deselected");
  property p_cfg_reset;
    $rose(rst_n) |-> trim_out == '0 && !shuffle_en && dll_cfg == '0;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("settings not cleared by reset");
endmodule

bind dcmc_core_ctrl dcmc_core_ctrl_asserts u_dcmc_core_ctrl_asserts (
  .clk(clk), .rst_n(rst_n),
  .half_band_doubling_filter_en(half_band_doubling_filter_en),
  .spi_csb_n(spi_csb_n), .spi_sdo_oe_n(spi_sdo_oe_n), .core_out(core_out),
  .shuffle_sel(shuffle_sel), .shuffle_en(shuffle_en), .trim_out(trim_out),
  .dll_cfg(dll_cfg)
);

// File: verif/dcmc_spi_host.sv
// Serial configuration host model for the register port
`timescale 1ns/100ps
module dcmc_spi_host
  import dcmc_pkg::*;
#(
  parameter logic [7:0] DLL_VAL = 8'h3c
) (
  input wire logic clk,
  output logic sclk,
  output logic csb_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  // Idle pins: clock still, deselected
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One frame, cut short when nbits is below 24
  task automatic xfer(input logic rd, input logic [14:0] addr,
                      input logic [7:0] wd, input int nbits,
                      output logic [7:0] rdat);
    logic [23:0] frame;
    frame = {rd, addr, wd};
    rdat = 8'h00;
    @(posedge clk);
    csb_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk);
      sdi <= frame[23-i];
      wait_clk(6);
      if (i >= 16)
        rdat[23-i] = sdo_oe_n ? ~sdo : sdo; // Undriven line reads wrong
      sclk <= 1'b1;
      wait_clk(6);
      sclk <= 1'b0;
    end
    wait_clk(6);
    csb_n <= 1'b1;
    sdi <= ~sdi; // Released data line flips
    wait_clk(6);
  endtask
  // Start-up load of the characterised locking-loop values
  task automatic dll_init();
    logic [7:0] unused;
    for (int i = 0; i < DLL_NREG; i++)
      xfer(1'b0, ADDR_DLL_FIRST + 15'(i), DLL_VAL ^ 8'(i), 24, unused);
  endtask
endmodule

// File: verif/dcmc_core_ctrl_test.sv
// Self-checking bench for the core mode and clock control block
`timescale 1ns/100ps
module dcmc_core_ctrl_test;
  import dcmc_pkg::*;
  localparam logic [7:0] DLL_V = 8'h3c;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] smp_data = 16'h0032;
  logic smp_valid = 1'b0;
  logic dbl_en = 1'b0;
  logic smp_ready, spi_sclk, spi_csb_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
  dcmc_core_s core_out;
  logic [2:0] shuffle_sel;
  logic shuffle_en, underrun, mon_en;
  dcmc_trim_s trim_out;
  logic [8*DLL_NREG-1:0] dll_cfg, dll_exp;
  logic [15:0] lfsr_r = 16'h0032;
  logic [15:0] rnd_r = 16'h0032;
  logic [15:0] prev_w, q[$];
  logic [1:0] mode_r;
  logic [7:0] rd, v, sk, du;
  logic [14:0] addrs[4] = '{ADDR_SKEW_TRIM, ADDR_DUTY_ADJ, ADDR_SHUFFLE,
                            ADDR_MODE_SEL};
  logic [7:0] masks[4] = '{MASK_SKEW_TRIM, MASK_DUTY_ADJ, MASK_SHUFFLE,
                           MASK_MODE_SEL};
  logic [1:0] modes[5] = '{2'b00, 2'b10, 2'b01, 2'b00, 2'b11};
  int error_cnt = 0;
  int comparisons = 0;
  int full_seen = 0;
  int seen;
  always #12.5 clk = ~clk;
  dcmc_core_ctrl u_dcmc_core_ctrl (.clk(clk), .rst_n(rst_n),
    .smp_data(smp_data), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .half_band_doubling_filter_en(dbl_en), .spi_sclk(spi_sclk),
    .spi_csb_n(spi_csb_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe_n(spi_sdo_oe_n), .core_out(core_out),
    .shuffle_sel(shuffle_sel), .shuffle_en(shuffle_en),
    .trim_out(trim_out), .dll_cfg(dll_cfg), .underrun(underrun));
  dcmc_spi_host #(.DLL_VAL(DLL_V)) u_dcmc_spi_host (.clk(clk),
    .sclk(spi_sclk), .csb_n(spi_csb_n), .sdi(spi_sdi), .sdo(spi_sdo),
    .sdo_oe_n(spi_sdo_oe_n));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Expected falling-half word for a mode
  function automatic logic [15:0] fall_exp(input logic [1:0] m,
                                           input logic [15:0] w);
    return (m == 2'b10) ? ZERO_WORD : (m == 2'b01) ? ~w : w;
  endfunction
  task automatic chk_port(input logic [95:0] got, input logic [95:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    chk_port({88'h0, got}, {88'h0, exp});
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Sample source: new random word after each accepted one
  always @(posedge clk) begin
    if (smp_valid && smp_ready) begin
      q.push_back(smp_data);
      lfsr_r = lfsr(lfsr_r);
      smp_data <= lfsr_r;
    end
  end
  // Core word monitor, sampled mid-cycle
  always @(negedge clk) begin
    if (mon_en === 1'b1) begin
      if (smp_ready === 1'b0)
        full_seen++;
      if (core_out.rise_half || (dbl_en && mode_r == 2'b00)) begin
        // Empty FIFO sends zero and raises underrun with it
        if (underrun === 1'b1)
          chk_port(96'(core_out.word), 96'(ZERO_WORD));
        else
          chk_port(96'(core_out.word),
                   96'(q.size() ? q.pop_front() : 16'h0));
      end else
        chk_port(96'(core_out.word),
                 96'(fall_exp(mode_r, prev_w)));
      prev_w = core_out.word;
    end
  end
  // Watchdog against a hang
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    mon_en = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      u_dcmc_spi_host.xfer(1'b1, addrs[i], 8'h00, 24, rd);
      chk_reg(rd, 8'h00);
    end
    // Corner values first, then random
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 4; i++) begin
        rnd_r = lfsr(rnd_r);
        v = (k == 0) ? 8'hff : (k == 1) ? 8'h20 : rnd_r[7:0];
        if (i == 0) sk = v;
        if (i == 1) du = v;
        if (i == 2) seen = int'(v[2]);
        u_dcmc_spi_host.xfer(1'b0, addrs[i], v, 24, rd);
        u_dcmc_spi_host.xfer(1'b1, addrs[i], 8'h00, 24, rd);
        chk_reg(rd, v & masks[i]);
      end
      chk_port(96'(trim_out), 96'({du[7], du[6] & du[4],
        du[6] ? du[3:0] : 4'h0, sk[5] ? 5'h00 : sk[4:0],
        sk[5] ? sk[4:0] : 5'h00}));
      chk_reg({7'h0, shuffle_en}, 8'(seen));
    end
    u_dcmc_spi_host.xfer(1'b0, 15'h0153, 8'hff, 24, rd);
    u_dcmc_spi_host.xfer(1'b1, 15'h0153, 8'h00, 24, rd);
    chk_reg(rd, 8'h00);
    u_dcmc_spi_host.xfer(1'b0, ADDR_MODE_SEL, 8'h00, 24, rd);
    u_dcmc_spi_host.xfer(1'b0, ADDR_MODE_SEL, 8'h01, 20, rd);
    u_dcmc_spi_host.xfer(1'b1, ADDR_MODE_SEL, 8'h00, 24, rd);
    chk_reg(rd, 8'h00);
    u_dcmc_spi_host.dll_init();
    for (int i = 0; i < DLL_NREG; i++)
      dll_exp[8*i +: 8] = DLL_V ^ 8'(i);
    chk_port(96'(dll_cfg), 96'(dll_exp));
    // Each feeding mode, baseband with doubling filter, reserved code
    for (int m = 0; m < 5; m++) begin
      mon_en = 1'b0;
      smp_valid <= 1'b0;
      repeat (16) @(posedge clk);
      q.delete();
      prev_w = ZERO_WORD;
      mode_r = modes[m];
      u_dcmc_spi_host.xfer(1'b0, ADDR_MODE_SEL, {6'h00, modes[m]}, 24, rd);
      dbl_en <= (m == 3);
      repeat (6) @(posedge clk);
      mon_en = 1'b1;
      smp_valid <= 1'b1;
      repeat (80) @(posedge clk);
    end
    chk_reg({7'h0, full_seen > 0}, 8'h01);
    smp_valid <= 1'b0;
    seen = 0;
    for (int t = 0; t < 40 && seen == 0; t++) begin
      @(negedge clk);
      if (underrun === 1'b1) seen = 1;
    end
    chk_reg(8'(seen), 8'h01);
    mon_en = 1'b0;
    u_dcmc_spi_host.xfer(1'b0, ADDR_SHUFFLE, 8'h04, 24, rd);
    seen = 0;
    for (int t = 0; t < 64 && seen == 0; t++) begin
      @(negedge clk);
      if (shuffle_sel !== 3'h0) seen = 1;
    end
    chk_reg(8'(seen), 8'h01);
    // Reset in mid-run returns every setting to zero
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    chk_port(96'(dll_cfg), 96'h0);
    chk_port(96'(trim_out), 96'h0);
    chk_reg({7'h0, shuffle_en}, 8'h00);
    u_dcmc_spi_host.xfer(1'b1, ADDR_MODE_SEL, 8'h00, 24, rd);
    chk_reg(rd, 8'h00);
    end_sim();
  end
endmodule
